// ==== hw/ls_commit_compare.v ====
`timescale 1ns/100ps
`include "ls_gate_hub_defines.vh"

// Registered comparison of the frame time left against the threshold
module ls_commit_compare #(
  parameter W = `LS_THRESH_WIDTH,
  parameter FW = 14
) (
  input  wire          i_sys_clk,
  input  wire          i_rst,
  input  wire [W-1:0]  i_threshold,
  input  wire [FW-1:0] i_frame_time_left,
  input  wire          i_request,
  output reg           o_valid,
  output reg           o_start
);

  // ==========================================================
  // Compare stage
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_start <= 1'b0;
    end else begin
      o_valid <= i_request;
      o_start <= i_request && (i_frame_time_left >= {{(FW-W){1'b0}}, i_threshold}); // RULE2 RULE3
    end
  end

endmodule // ls_commit_compare

// ==== hw/ls_gate_hub_defines.vh ====
`ifndef LS_GATE_HUB_DEFINES_VH
`define LS_GATE_HUB_DEFINES_VH

// ==========================================================
// Register byte offsets
`define REG_LS_THRESHOLD_ADDR   8'h00
`define REG_RH_DESC_A_ADDR      8'h04
`define REG_LS_STATUS_ADDR      8'h08

// ==========================================================
// Low-speed threshold
`define LS_THRESH_WIDTH         12
`define LS_THRESH_RESET         12'h628

// ==========================================================
// Root hub descriptor A fields
`define DA_SETTLE_HI            31
`define DA_SETTLE_LO            24
`define DA_OC_ABSENT_BIT        12
`define DA_OC_GRAN_BIT          11
`define DA_COMPOUND_BIT         10
`define DA_ALWAYS_PWR_BIT       9
`define DA_PWR_SW_GRAN_BIT      8
`define DA_PORT_COUNT_HI        7
`define DA_PORT_COUNT_LO        0
`define SETTLE_RESET            8'h02
`define PORT_COUNT_VALUE        8'h01

// ==========================================================
// Timing
`define SETTLE_UNIT_MS          2
`define CLK_FREQ_KHZ            40000
`define SETTLE_UNIT_CYCLES      (`SETTLE_UNIT_MS * `CLK_FREQ_KHZ)

`endif

// ==== hw/usb_host_ls_gate_and_hub_desc.v ====
`timescale 1ns/100ps
`include "ls_gate_hub_defines.vh"

// Function
// RULE1 - A 12-bit threshold decides if an 8-byte low-speed packet still fits in the frame.
// RULE2 - Before each low-speed transaction the threshold is compared with frame time left.
// RULE3 - The transaction starts only if frame time left is not below the threshold, else defers.
// RULE4 - The core never alters the threshold; software sets it once and leaves it.
// RULE5 - Descriptor bits 31-24 hold the power settle time in units of 2 ms.
// RULE6 - Software waits at least the settle time after port power-on before access.
// RULE7 - Bit 12 set means no overcurrent protection; clear means it is reported.
// RULE8 - With bit 12 clear, the granularity bit picks global or per-port reporting.
// RULE9 - Software emulates length, type and current fields of the hub descriptor.
// RULE10 - Granularity bit 0 is collective reporting, 1 is per-port reporting.
// RULE11 - The compound device flag always reads zero.
// RULE12 - The downstream port count is read-only and reads one.
// RULE13 - Reserved bits read zero and ignore writes.
module usb_host_ls_gate_and_hub_desc #(
  parameter FW = 14
) (
  input  wire                   i_sys_clk,
  input  wire                   i_rst,
  input  wire [7:0]             i_addr,
  input  wire [31:0]            i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [31:0]            o_rdata,
  input  wire [FW-1:0]          i_frame_time_left,
  input  wire                   i_ls_request,
  input  wire                   i_port_power_on,
  input  wire                   i_port_overcurrent,
  output reg                    o_ls_valid,
  output reg                    o_ls_start,
  output reg                    o_ls_defer,
  output reg  [`LS_THRESH_WIDTH-1:0] o_low_speed_threshold,
  output reg                    o_overcurrent_global,
  output reg                    o_overcurrent_port,
  output reg                    o_ports_always_powered,
  output reg                    o_port_power_switch_granularity,
  output reg                    o_port_power_good
);

  // ==========================================================
  // Register state
  reg [`LS_THRESH_WIDTH-1:0] low_speed_threshold;
  reg [7:0]            port_power_settle_time;
  reg                  overcurrent_absent;
  reg                  overcurrent_report_granularity;
  reg                  ports_always_powered;
  reg                  port_power_switch_granularity;
  reg [FW-1:0]         ftl_s1;
  reg [FW-1:0]         ftl_s2;
  reg                  req_s1;
  reg                  req_s2;
  reg                  pwr_s1;
  reg                  pwr_s2;
  reg                  oc_s1;
  reg                  oc_s2;
  reg                  pwr_q;
  reg [31:0]           unit_cnt;
  reg [7:0]            units_left;
  reg                  settling;
  wire                 cmp_valid;
  wire                 cmp_start;
  wire [31:0]          desc_a;
  reg  [31:0]          next_rdata;
  reg                  last_start;
  reg                  last_defer;

  // Last count of one settle unit; sized here so the compare below
  // does not mix a bare integer with the 32-bit counter
  localparam [31:0] SETTLE_LAST = `SETTLE_UNIT_CYCLES - 1;

  // ==========================================================
  // Helper functions
  // Exact byte-offset match; the low two bits take part, so a misaligned
  // access hits nothing rather than aliasing onto a register
  function addr_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // Reserved and fixed fields are built here, never stored, so a write
  // cannot reach them
  function [31:0] pack_desc_a;
    input [7:0] settle;
    input       oc_absent;
    input       oc_gran;
    input       always_pwr;
    input       pwr_sw_gran;
    begin
      pack_desc_a = 32'h0000_0000; // RULE13
      pack_desc_a[`DA_SETTLE_HI:`DA_SETTLE_LO] = settle; // RULE5
      pack_desc_a[`DA_OC_ABSENT_BIT]   = oc_absent; // RULE7
      pack_desc_a[`DA_OC_GRAN_BIT]     = oc_gran; // RULE10
      pack_desc_a[`DA_COMPOUND_BIT]    = 1'b0; // RULE11
      pack_desc_a[`DA_ALWAYS_PWR_BIT]  = always_pwr;
      pack_desc_a[`DA_PWR_SW_GRAN_BIT] = pwr_sw_gran;
      pack_desc_a[`DA_PORT_COUNT_HI:`DA_PORT_COUNT_LO] = `PORT_COUNT_VALUE; // RULE12
    end
  endfunction

  assign desc_a = pack_desc_a(
    port_power_settle_time,
    overcurrent_absent,
    overcurrent_report_granularity,
    ports_always_powered,
    port_power_switch_granularity
  );

  // ==========================================================
  // Register writes; the core itself never changes the threshold
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      low_speed_threshold            <= `LS_THRESH_RESET;
      port_power_settle_time         <= `SETTLE_RESET;
      overcurrent_absent             <= 1'b0;
      overcurrent_report_granularity <= 1'b0;
      ports_always_powered           <= 1'b0;
      port_power_switch_granularity  <= 1'b0;
    end else if (i_wr) begin
      // Software may rewrite the threshold at any time; keeping it steady
      // while the schedule runs is the driver's duty, not enforced here
      if (addr_hit(i_addr, `REG_LS_THRESHOLD_ADDR)) begin
        low_speed_threshold <= i_wdata[`LS_THRESH_WIDTH-1:0]; // RULE1 RULE4
      end
      if (addr_hit(i_addr, `REG_RH_DESC_A_ADDR)) begin
        port_power_settle_time         <= i_wdata[`DA_SETTLE_HI:`DA_SETTLE_LO]; // RULE5
        overcurrent_absent             <= i_wdata[`DA_OC_ABSENT_BIT]; // RULE7
        overcurrent_report_granularity <= i_wdata[`DA_OC_GRAN_BIT]; // RULE10
        ports_always_powered           <= i_wdata[`DA_ALWAYS_PWR_BIT];
        port_power_switch_granularity  <= i_wdata[`DA_PWR_SW_GRAN_BIT];
      end
    end
  end

  // ==========================================================
  // Read port; unmapped addresses read zero
  always @* begin
    case (i_addr)
      `REG_LS_THRESHOLD_ADDR: next_rdata = {20'h00000, low_speed_threshold}; // RULE13
      `REG_RH_DESC_A_ADDR:    next_rdata = desc_a;
      `REG_LS_STATUS_ADDR:    next_rdata = {29'h00000000, o_port_power_good,
                                            last_defer, last_start};
      default:                next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Inputs from the frame timer and port pins come from outside: two flops each.
  // The multi-bit count is assumed stable across a compare request.
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      ftl_s1 <= {FW{1'b0}};
      ftl_s2 <= {FW{1'b0}};
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      pwr_s1 <= 1'b0;
      pwr_s2 <= 1'b0;
      oc_s1  <= 1'b0;
      oc_s2  <= 1'b0;
    end else begin
      ftl_s1 <= i_frame_time_left;
      ftl_s2 <= ftl_s1;
      req_s1 <= i_ls_request;
      req_s2 <= req_s1;
      pwr_s1 <= i_port_power_on;
      pwr_s2 <= pwr_s1;
      oc_s1  <= i_port_overcurrent;
      oc_s2  <= oc_s1;
    end
  end

  // ==========================================================
  // Low-speed commit gate
  ls_commit_compare #(
    .W  (`LS_THRESH_WIDTH),
    .FW (FW)
  ) u_cmp (
    .i_sys_clk         (i_sys_clk),
    .i_rst             (i_rst),
    .i_threshold       (low_speed_threshold),
    .i_frame_time_left (ftl_s2),
    .i_request         (req_s2),
    .o_valid           (cmp_valid),
    .o_start           (cmp_start)
  );

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ls_valid            <= 1'b0;
      o_ls_start            <= 1'b0;
      o_ls_defer            <= 1'b0;
      o_low_speed_threshold <= `LS_THRESH_RESET;
    end else begin
      o_ls_valid            <= cmp_valid;
      o_ls_start            <= cmp_valid & cmp_start; // RULE3
      o_ls_defer            <= cmp_valid & ~cmp_start; // RULE3
      o_low_speed_threshold <= low_speed_threshold; // RULE4
    end
  end

  // ==========================================================
  // Last decision, kept for the status register; the output pulses
  // stand for one cycle only and software would almost never see them
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      last_start <= 1'b0;
      last_defer <= 1'b0;
    end else if (cmp_valid) begin
      last_start <= cmp_start; // RULE3
      last_defer <= ~cmp_start; // RULE3
    end
  end

  // ==========================================================
  // Overcurrent routing by mode
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_overcurrent_global <= 1'b0;
      o_overcurrent_port   <= 1'b0;
    end else begin
      o_overcurrent_global <= ~overcurrent_absent & ~overcurrent_report_granularity & oc_s2; // RULE8
      o_overcurrent_port   <= ~overcurrent_absent & overcurrent_report_granularity & oc_s2; // RULE8
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ports_always_powered          <= 1'b0;
      o_port_power_switch_granularity <= 1'b0;
    end else begin
      o_ports_always_powered          <= ports_always_powered;
      o_port_power_switch_granularity <= port_power_switch_granularity;
    end
  end

  // ==========================================================
  // Power good indication after the settle time, a helper for software
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      pwr_q             <= 1'b0;
      unit_cnt          <= 32'h0000_0000;
      units_left        <= 8'h00;
      settling          <= 1'b0;
      o_port_power_good <= 1'b0;
    end else begin
      pwr_q <= pwr_s2;
      if (!pwr_s2) begin
        settling          <= 1'b0;
        o_port_power_good <= 1'b0;
      end else if (!pwr_q) begin
        settling          <= (port_power_settle_time != 8'h00);
        o_port_power_good <= (port_power_settle_time == 8'h00);
        units_left        <= port_power_settle_time; // RULE5
        unit_cnt          <= 32'h0000_0000;
      end else if (settling) begin
        // Whole units only: the wait is never shorter than asked
        if (unit_cnt == SETTLE_LAST) begin
          unit_cnt <= 32'h0000_0000;
          if (units_left == 8'h01) begin
            settling          <= 1'b0;
            o_port_power_good <= 1'b1; // RULE6
          end
          units_left <= units_left - 8'h01;
        end else begin
          unit_cnt <= unit_cnt + 32'h0000_0001;
        end
      end
    end
  end

endmodule // usb_host_ls_gate_and_hub_desc

// ==== testbench/ls_gate_props.sv ====
`timescale 1ns/100ps
// ==========================================================
// Port-level checker
module ls_gate_props #(
  parameter FW = 14
) (
  input wire          i_sys_clk,
  input wire          i_rst,
  input wire [7:0]    i_addr,
  input wire          i_wr,
  input wire          i_rd,
  input wire [31:0]   o_rdata,
  input wire [FW-1:0] i_frame_time_left,
  input wire          i_ls_request,
  input wire          i_port_power_on,
  input wire          o_ls_valid,
  input wire          o_ls_start,
  input wire          o_ls_defer,
  input wire [11:0]   o_low_speed_threshold,
  input wire          o_overcurrent_global,
  input wire          o_overcurrent_port,
  input wire          o_port_power_good
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  desc_fixed_a: assert property ($past(i_rd) && $past(i_addr) == 8'h04 |->
    o_rdata[23:13] == 11'h0 && o_rdata[10] == 1'b0 && o_rdata[7:0] == 8'h01)
    else $error("descriptor fixed fields wrong");
  thr_resv_a: assert property ($past(i_rd) && $past(i_addr) == 8'h00 |->
    o_rdata[31:12] == 20'h0) else $error("threshold upper bits not zero");
  ls_decide_a: assert property (i_ls_request && !$past(i_ls_request) |-> ##4
    o_ls_valid && (o_ls_start == ($past(i_frame_time_left, 4) >=
    $past(o_low_speed_threshold, 4)))) else $error("low-speed decision wrong or late");
  ls_pair_a: assert property (o_ls_valid == (o_ls_start ^ o_ls_defer))
    else $error("decision outputs inconsistent");
  thr_hold_a: assert property (!$stable(o_low_speed_threshold) |->
    ($past(i_wr) && $past(i_addr) == 8'h00) || ($past(i_wr, 2) && $past(i_addr, 2) == 8'h00))
    else $error("threshold changed without a write");
  oc_excl_a: assert property (!(o_overcurrent_global && o_overcurrent_port))
    else $error("overcurrent reported on both paths");
  pgood_a: assert property ($rose(o_port_power_good) |-> $past(i_port_power_on, 3))
    else $error("power good without port power");
  cover property (o_ls_start);
  cover property (o_ls_defer);
  cover property ($rose(o_port_power_good));
endmodule // ls_gate_props

bind usb_host_ls_gate_and_hub_desc ls_gate_props #(.FW(FW)) ls_gate_props_inst (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_frame_time_left(i_frame_time_left), .i_ls_request(i_ls_request),
  .i_port_power_on(i_port_power_on), .o_ls_valid(o_ls_valid), .o_ls_start(o_ls_start),
  .o_ls_defer(o_ls_defer), .o_low_speed_threshold(o_low_speed_threshold),
  .o_overcurrent_global(o_overcurrent_global), .o_overcurrent_port(o_overcurrent_port),
  .o_port_power_good(o_port_power_good));

// ==== testbench/tb_usb_host_ls_gate_and_hub_desc.sv ====
`timescale 1ns/100ps
module tb_usb_host_ls_gate_and_hub_desc;
  reg         i_sys_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  reg         i_ls_request = 1'b0, pwr_cmd = 1'b0, fault_cmd = 1'b0;
  reg  [7:0]  i_addr = 8'h00;
  reg  [31:0] i_wdata = 32'h0;
  reg  [13:0] i_frame_time_left = 14'h0;
  wire [31:0] o_rdata;
  wire [11:0] o_low_speed_threshold;
  wire        pwr_on, oc, o_ls_valid, o_ls_start, o_ls_defer, oc_glob, oc_port, pgood;
  wire        always_pwr, pwr_sw_gran;
  integer     miscompares = 0, tests_run = 0, cycles = 0, i;
  reg  [31:0] oc_cfg [0:2];
  reg  [1:0]  oc_exp [0:2];
  usb_port_model usb_port_model_inst (.i_sys_clk(i_sys_clk), .i_power_cmd(pwr_cmd),
    .i_fault_cmd(fault_cmd), .o_power_on(pwr_on), .o_overcurrent(oc));
  usb_host_ls_gate_and_hub_desc usb_host_ls_gate_and_hub_desc_inst (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_frame_time_left(i_frame_time_left), .i_ls_request(i_ls_request),
    .i_port_power_on(pwr_on), .i_port_overcurrent(oc), .o_ls_valid(o_ls_valid),
    .o_ls_start(o_ls_start), .o_ls_defer(o_ls_defer),
    .o_low_speed_threshold(o_low_speed_threshold), .o_overcurrent_global(oc_glob),
    .o_overcurrent_port(oc_port), .o_ports_always_powered(always_pwr),
    .o_port_power_switch_granularity(pwr_sw_gran), .o_port_power_good(pgood));
  // ==========================================================
  // Clock and hang guard
  always #12.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 95000) begin
      miscompares = miscompares + 1;
      summarize;
    end
  end
  // ==========================================================
  // Shared tasks
  task chk(input [8*12:1] name, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge i_sys_clk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
      @(posedge i_sys_clk) i_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge i_sys_clk) begin i_rd <= 1'b1; i_addr <= a; end
      @(posedge i_sys_clk) i_rd <= 1'b0;
      #1 chk("rdata", e, o_rdata);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_regs;
    begin
      rd(8'h00, 32'h00000628);
      rd(8'h04, 32'h02000001);
      rd(8'h0C, 32'h0);
      wr(8'h00, 32'hFFFFFFFF);
      rd(8'h00, 32'h00000FFF);
      wr(8'h04, 32'hFFFFFFFF);
      rd(8'h04, 32'hFF001B01);
      chk("pwr_modes", 32'h3, {30'h0, always_pwr, pwr_sw_gran});
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h00000001);
    end
  endtask
  // Equal counts must still start, so the boundary sits in the middle
  task t_ls_gate;
    begin
      wr(8'h00, 32'h100);
      for (i = 0; i < 3; i = i + 1) begin
        @(posedge i_sys_clk) i_frame_time_left <= 14'h0FF + i[13:0];
        repeat (4) @(posedge i_sys_clk);
        @(posedge i_sys_clk) i_ls_request <= 1'b1;
        @(posedge i_sys_clk) i_ls_request <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1 chk("ls_gate", (i == 0) ? 32'h5 : 32'h6, {o_ls_valid, o_ls_start, o_ls_defer});
      end
      chk("threshold", 32'h100, {20'h0, o_low_speed_threshold});
    end
  endtask
  task t_overcurrent;
    begin
      @(posedge i_sys_clk) pwr_cmd <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
        wr(8'h04, oc_cfg[i]);
        @(posedge i_sys_clk) fault_cmd <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        #1 chk("oc_route", {30'h0, oc_exp[i]}, {30'h0, oc_glob, oc_port});
        @(posedge i_sys_clk) fault_cmd <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
      end
    end
  endtask
  // One settle unit is the shortest nonzero wait, about 80k cycles
  task t_power_good;
    begin
      @(posedge i_sys_clk) pwr_cmd <= 1'b0;
      wr(8'h04, 32'h01000000);
      repeat (10) @(posedge i_sys_clk);
      @(posedge i_sys_clk) pwr_cmd <= 1'b1;
      repeat (79990) @(posedge i_sys_clk);
      #1 chk("pgood_early", 32'h0, {31'h0, pgood});
      for (i = 0; i < 40 && pgood !== 1'b1; i = i + 1) @(posedge i_sys_clk);
      #1 chk("pgood", 32'h1, {31'h0, pgood});
      rd(8'h08, 32'h00000005);
    end
  endtask
  initial begin
    oc_cfg[0] = 32'h0;
    oc_cfg[1] = 32'h800;
    oc_cfg[2] = 32'h1800;
    oc_exp[0] = 2'b10;
    oc_exp[1] = 2'b01;
    oc_exp[2] = 2'b00;
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_regs;
    t_ls_gate;
    t_overcurrent;
    t_power_good;
    summarize;
  end
endmodule // tb_usb_host_ls_gate_and_hub_desc

// ==== testbench/usb_port_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// Downstream port: fault only shows while powered
module usb_port_model (
  input  wire i_sys_clk,
  input  wire i_power_cmd,
  input  wire i_fault_cmd,
  output reg  o_power_on,
  output reg  o_overcurrent
);
  initial begin
    o_power_on = 1'b0;
    o_overcurrent = 1'b0;
  end
  always @(posedge i_sys_clk) begin
    o_power_on <= i_power_cmd;
    o_overcurrent <= i_power_cmd & i_fault_cmd;
  end
endmodule // usb_port_model
